//--- core/flash_host_consts.svh
// Timing counts, command values and unlock addresses for the flash host controller
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH
`define CLK_PERIOD_NS        10
`define SELECT_ACCESS_NS     90
`define SELECT_ACCESS_CYC    ((`SELECT_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS       50
`define WRITE_PULSE_CYC      ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_MIN_NS   500
`define RESET_PULSE_MIN_CYC  ((`RESET_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_TO_READ_NS     50
`define RESET_TO_READ_CYC    ((`RESET_TO_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_RESET            16'h00F0
`define CMD_UNLOCK1          16'h00AA
`define CMD_UNLOCK2          16'h0055
`define CMD_IDENT            16'h0090
`define CMD_PROGRAM          16'h00A0
`define CMD_ERASE_SETUP      16'h0080
`define CMD_CHIP_ERASE       16'h0010
`define CMD_SECTOR_ERASE     16'h0030
`define CMD_BYPASS_ENTER     16'h0020
`define CMD_BYPASS_EXIT1     16'h0090
`define CMD_BYPASS_EXIT2     16'h0000
`define ADDR_WORD_U1         11'h555
`define ADDR_WORD_U2         11'h2AA
`define ADDR_BYTE_U1         12'hAAA
`define ADDR_BYTE_U2         12'h555
`define ADDR_ID_MFR          18'h00000
`define ADDR_ID_DEV          18'h00001
`endif

//--- core/flash_host_pkg.sv
// Types shared by the flash host controller
package flash_host_pkg;
  typedef enum logic [3:0] {
    OP_READ, OP_PROGRAM, OP_BYPASS_PROG, OP_BYPASS_ENTER, OP_BYPASS_EXIT,
    OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_READ_ID, OP_RESET_CMD, OP_HW_RESET
  } op_t;
  typedef struct packed {
    op_t         op;
    logic [17:0] addr;
    logic [15:0] data;
    logic        byte_mode;
  } req_t;
  typedef struct packed {
    logic        chip_select_n;
    logic        output_gate_n;
    logic        write_strobe_n;
    logic        hard_reset_n;
    logic        byte_n;
    logic [18:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
  } pins_t;
endpackage

//--- core/flash_host_ctrl.sv
// Host-side controller driving an asynchronous parallel flash through its pins
//
// What this block does
// - Read: select and gate low, strobe high
// - Write: select and strobe low, gate high
// - Unlock bypass programs in two writes
// - No read data before reset-to-read delay
// - Reset command returns to array reading
// - Unlock addresses 555/2AA word, AAA/555 byte
// - Only reset command or hardware reset leaves identifier mode
`timescale 1ns/10ps
`include "flash_host_consts.svh"

module flash_host_ctrl
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Request side
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire flash_host_pkg::req_t req,
  output logic                      rsp_valid,
  output logic [15:0]               rsp_data,
  output logic                      busy,
  // Flash pins
  output flash_host_pkg::pins_t     pins,
  input  wire logic [15:0]          dq_in,
  input  wire logic                 done_flag_n
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_WR_LOW, ST_WR_HIGH, ST_RST_LOW, ST_RST_WAIT, ST_WAIT_DONE
  } state_t;

  typedef struct packed {
    state_t      st;
    req_t        cur;
    logic [2:0]  idx;
    logic [2:0]  cnt_len;
    logic [7:0]  cnt;
    logic        in_ident;
    pins_t       p;
    logic [15:0] rdata;
    logic        rvalid;
    logic [1:0]  done_sync;
    logic [31:0] dq_sync;
  } state_s_t;

  state_s_t s_q, s_d;

  // Number of write cycles each operation issues
  function automatic logic [2:0] seq_len(input op_t op);
    case (op)
      OP_PROGRAM:                              seq_len = 3'd4;
      OP_READ_ID, OP_BYPASS_ENTER:             seq_len = 3'd3;
      OP_CHIP_ERASE, OP_SECTOR_ERASE:          seq_len = 3'd6;
      OP_BYPASS_PROG, OP_BYPASS_EXIT:          seq_len = 3'd2;
      OP_RESET_CMD:                            seq_len = 3'd1;
      default:                                 seq_len = 3'd0;
    endcase
  endfunction

  // Unlock address for cycle position (word or byte mode)
  function automatic logic [18:0] unlock_addr(input logic first, input logic bm);
    if (bm)
      unlock_addr = first ? {7'h00, `ADDR_BYTE_U1} : {7'h00, `ADDR_BYTE_U2};
    else
      unlock_addr = first ? {7'h00, `ADDR_WORD_U1, 1'b0} : {7'h00, `ADDR_WORD_U2, 1'b0};
  endfunction

  // Address and data of write cycle i of an operation
  function automatic logic [34:0] cyc(input req_t r, input logic [2:0] i);
    logic [18:0] a;
    logic [15:0] d;
    logic [18:0] ua;
    a  = unlock_addr(1'b1, r.byte_mode);
    d  = `CMD_UNLOCK1;
    ua = {r.addr, 1'b0};
    case (r.op)
      OP_RESET_CMD:
      begin
        a = ua;
        d = `CMD_RESET;
      end
      OP_BYPASS_PROG:
      begin
        a = (i == 3'd0) ? unlock_addr(1'b1, r.byte_mode) : ua;
        d = (i == 3'd0) ? `CMD_PROGRAM : r.data;
      end
      OP_BYPASS_EXIT:
      begin
        a = ua;
        d = (i == 3'd0) ? `CMD_BYPASS_EXIT1 : `CMD_BYPASS_EXIT2;
      end
      default:
      begin
        case (i)
          3'd0: begin a = unlock_addr(1'b1, r.byte_mode); d = `CMD_UNLOCK1; end
          3'd1, 3'd4: begin a = unlock_addr(1'b0, r.byte_mode); d = `CMD_UNLOCK2; end
          3'd2:
          begin
            a = unlock_addr(1'b1, r.byte_mode);
            case (r.op)
              OP_PROGRAM:      d = `CMD_PROGRAM;
              OP_READ_ID:      d = `CMD_IDENT;
              OP_BYPASS_ENTER: d = `CMD_BYPASS_ENTER;
              default:         d = `CMD_ERASE_SETUP;
            endcase
          end
          3'd3:
          begin
            // Program data word, or first unlock of the erase confirm pair
            a = (r.op == OP_PROGRAM) ? ua : unlock_addr(1'b1, r.byte_mode);
            d = (r.op == OP_PROGRAM) ? r.data : `CMD_UNLOCK1;
          end
          default:
          begin
            // Sector picked by upper bits
            a = (r.op == OP_CHIP_ERASE) ? unlock_addr(1'b1, r.byte_mode) : ua;
            d = (r.op == OP_CHIP_ERASE) ? `CMD_CHIP_ERASE : `CMD_SECTOR_ERASE;
          end
        endcase
      end
    endcase
    cyc = {a, d};
  endfunction

  assign req_ready = (s_q.st == ST_IDLE);
  assign pins      = s_q.p;
  assign rsp_valid = s_q.rvalid;
  assign rsp_data  = s_q.rdata;
  assign busy      = (s_q.st != ST_IDLE);

  always_comb
  begin
    logic [34:0] c;
    c = '0;
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.done_sync = {s_q.done_sync[0], done_flag_n};
    s_d.dq_sync   = {s_q.dq_sync[15:0], dq_in};
    case (s_q.st)
      ST_IDLE:
      begin
        // Parked in standby: deselected, gate high so the device tristates
        s_d.p.chip_select_n  = 1'b1;
        s_d.p.output_gate_n  = 1'b1;
        s_d.p.write_strobe_n = 1'b1;
        s_d.p.dq_oe          = 1'b0;
        if (req_valid)
        begin
          s_d.cur = req;
          s_d.idx = 3'd0;
          s_d.cnt = 8'd0;
          s_d.cnt_len = seq_len(req.op);
          s_d.p.byte_n = ~req.byte_mode;
          case (req.op)
            OP_READ:
            begin
              s_d.st = ST_RD;
              s_d.p.addr = {req.addr, 1'b0};
              s_d.p.chip_select_n = 1'b0;
              s_d.p.output_gate_n = 1'b0;
            end
            OP_HW_RESET:
            begin
              s_d.st = ST_RST_LOW;
              s_d.p.hard_reset_n = 1'b0;
            end
            default:
              s_d.st = ST_WR_LOW;
          endcase
        end
      end
      ST_RD:
      begin
        // Device keeps array read mode, no command needed
        s_d.cnt = s_q.cnt + 8'd1;
        // Two extra cycles cover the data synchroniser
        if (s_q.cnt == 8'(`SELECT_ACCESS_CYC + 2))
        begin
          s_d.rdata  = s_q.cur.byte_mode ? {8'h00, s_q.dq_sync[23:16]} : s_q.dq_sync[31:16];
          s_d.rvalid = 1'b1;
          s_d.st     = ST_IDLE;
          s_d.p.chip_select_n = 1'b1;
          s_d.p.output_gate_n = 1'b1;
        end
      end
      ST_WR_LOW:
      begin
        c = cyc(s_q.cur, s_q.idx);
        s_d.p.addr   = c[34:16];
        s_d.p.dq_out = c[15:0];
        s_d.p.dq_oe  = 1'b1;                             // Gate stays high, no contention
        s_d.p.output_gate_n  = 1'b1;
        s_d.p.chip_select_n  = 1'b0;
        s_d.p.write_strobe_n = 1'b0;
        s_d.cnt = s_q.cnt + 8'd1;
        if (s_q.cnt == 8'(`WRITE_PULSE_CYC))
        begin
          s_d.cnt = 8'd0;
          s_d.st  = ST_WR_HIGH;
          s_d.p.write_strobe_n = 1'b1;                   // Data latched on rising edge
        end
      end
      ST_WR_HIGH:
      begin
        s_d.p.chip_select_n = 1'b1;
        s_d.cnt = s_q.cnt + 8'd1;
        if (s_q.cnt == 8'(`WRITE_PULSE_CYC))
        begin
          s_d.cnt   = 8'd0;
          s_d.p.dq_oe = 1'b0;
          s_d.idx   = s_q.idx + 3'd1;
          if (s_q.idx + 3'd1 == s_q.cnt_len)
          begin
            if (s_q.cur.op == OP_READ_ID)
              s_d.in_ident = 1'b1;
            else if (s_q.cur.op == OP_RESET_CMD)
              s_d.in_ident = 1'b0;
            s_d.st = (s_q.cur.op == OP_PROGRAM || s_q.cur.op == OP_BYPASS_PROG ||
                      s_q.cur.op == OP_CHIP_ERASE || s_q.cur.op == OP_SECTOR_ERASE)
                     ? ST_WAIT_DONE : ST_IDLE;
          end
          else
            s_d.st = ST_WR_LOW;
        end
      end
      ST_WAIT_DONE:
      begin
        // Deselected while the embedded algorithm runs; wait for flag release
        s_d.cnt = (s_q.cnt == 8'hFF) ? s_q.cnt : s_q.cnt + 8'd1;
        if (s_q.cnt > 8'd3 && s_q.done_sync[1])
          s_d.st = ST_IDLE;
      end
      ST_RST_LOW:
      begin
        s_d.in_ident = 1'b0;
        s_d.p.chip_select_n = 1'b1;
        s_d.p.dq_oe = 1'b0;
        s_d.cnt = s_q.cnt + 8'd1;
        if (s_q.cnt == 8'(`RESET_PULSE_MIN_CYC))
        begin
          s_d.cnt = 8'd0;
          s_d.p.hard_reset_n = 1'b1;
          s_d.st = ST_RST_WAIT;
        end
      end
      ST_RST_WAIT:
      begin
        // Hold off reads until recovery and busy flag release
        s_d.cnt = (s_q.cnt == 8'hFF) ? s_q.cnt : s_q.cnt + 8'd1;
        if (s_q.cnt >= 8'(`RESET_TO_READ_CYC) && s_q.done_sync[1])
          s_d.st = ST_IDLE;
      end
      default:
        s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.p.chip_select_n  <= 1'b1;
      s_q.p.output_gate_n  <= 1'b1;
      s_q.p.write_strobe_n <= 1'b1;
      s_q.p.hard_reset_n   <= 1'b1;
      s_q.p.byte_n         <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  sequence strobe_low_s;
    !pins.write_strobe_n;
  endsequence

  read_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.output_gate_n |-> !pins.chip_select_n && pins.write_strobe_n)
    else $error("read cycle with bad strobes");
  write_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    strobe_low_s |-> !pins.chip_select_n && pins.output_gate_n && pins.dq_oe)
    else $error("write cycle with bad strobes");
  no_contention_a: assert property (@(posedge clk) disable iff (!rst_n)
    pins.dq_oe |-> pins.output_gate_n)
    else $error("host drives data while gate low");
  reset_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pins.hard_reset_n) |-> !pins.hard_reset_n [*8])
    else $error("reset pulse too short");
  reset_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins.hard_reset_n) |-> pins.output_gate_n [*5])
    else $error("read too soon after reset");
  read_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pins.output_gate_n) |-> !rsp_valid [*8])
    else $error("read data taken before access time");
  ident_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_q.in_ident) |-> s_q.cur.op == OP_READ_ID)
    else $error("identifier mode without identifier command");
  ident_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(s_q.in_ident) |-> s_q.cur.op inside {OP_RESET_CMD, OP_HW_RESET})
    else $error("identifier mode left without reset");
  reset_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
    strobe_low_s ##0 (s_q.cur.op == OP_RESET_CMD) |-> pins.dq_out == `CMD_RESET)
    else $error("reset command value wrong");

endmodule // flash_host_ctrl

//--- verif/flash_dev_model.sv
// Behavioural flash device seen from its pins, used as the far side of the host controller
`timescale 1ns/10ps

module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [15:0] MFR_CODE   = 16'h00A5, // Arbitrary identity value
  parameter logic [15:0] DEV_CODE   = 16'h5A3C, // Arbitrary identity value
  parameter int          PROG_CYC   = 20,
  parameter int          ERASE_CYC  = 60,
  parameter int          READY_CYC  = 30,
  parameter int          ACC_CYC    = 9,
  parameter int          RH_CYC     = 5,
  parameter int          SECT_SHIFT = 14
)
(
  // Clock for the model's own timers
  input  wire logic                 clk,
  // Device pins
  input  wire flash_host_pkg::pins_t pins,
  output logic [15:0]               dq,
  output logic                      done_flag_n
);
  logic [15:0] mem [2**18];
  logic [15:0] last;
  logic [15:0] val;
  logic [15:0] wd_q;
  logic [18:0] wa_q;
  logic [7:0]  d;
  logic        wr_q;
  int          st, acc, rh, busy, pk, pa;
  logic [15:0] pd;
  wire sel = !pins.chip_select_n && !pins.output_gate_n && pins.hard_reset_n;
  wire wr  = !pins.chip_select_n && !pins.write_strobe_n && pins.hard_reset_n;

  function automatic logic u1(logic [18:0] a, logic w);
    return w ? a[11:1] == 11'h555 : a[11:0] == 12'hAAA;
  endfunction
  function automatic logic u2(logic [18:0] a, logic w);
    return w ? a[11:1] == 11'h2AA : a[11:0] == 12'h555;
  endfunction

  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {st, acc, busy, pk, wr_q, last} = '0;
    rh = RH_CYC;
  end

  // Commands act when the strobe or select rises, on the latched values
  always @(posedge clk)
  begin
    last = dq;
    acc  = sel ? acc + 1 : 0;
    rh   = !pins.hard_reset_n ? 0 : (rh < RH_CYC ? rh + 1 : rh);
    if (busy > 0) begin
      busy--;
      if (busy == 0 && pk == 1) mem[pa] = mem[pa] & pd;
      if (busy == 0 && pk == 2) foreach (mem[i]) mem[i] = 16'hFFFF;
      if (busy == 0 && pk == 3)
        for (int i = 0; i < 2**SECT_SHIFT; i++) mem[((pa >> SECT_SHIFT) << SECT_SHIFT) + i] = 16'hFFFF;
    end
    if (!pins.hard_reset_n) begin
      st = 0;
      pk = 0;
      if (busy > READY_CYC) busy = READY_CYC;
    end else if (wr_q && !wr && busy == 0) begin
      d = wd_q[7:0];
      if (d == 8'hF0) st = 0;
      else case (st)
        0: st = (u1(wa_q, pins.byte_n) && d == 8'hAA) ? 1 : 0;
        1: st = (u2(wa_q, pins.byte_n) && d == 8'h55) ? 2 : 0;
        2: st = !u1(wa_q, pins.byte_n) ? 0 : d == 8'h90 ? 3 : d == 8'hA0 ? 4 :
                d == 8'h80 ? 5 : d == 8'h20 ? 8 : 0;
        3: st = 3;
        5: st = (u1(wa_q, pins.byte_n) && d == 8'hAA) ? 6 : 0;
        6: st = (u2(wa_q, pins.byte_n) && d == 8'h55) ? 7 : 0;
        7: begin
          pk   = d == 8'h10 ? 2 : d == 8'h30 ? 3 : 0;
          pa   = wa_q[18:1];
          busy = pk != 0 ? ERASE_CYC : 0;
          st   = 0;
        end
        8: st = d == 8'hA0 ? 9 : d == 8'h90 ? 10 : 8;
        10: st = d == 8'h00 ? 0 : 8;
        default: begin
          {pk, pa, pd, busy} = {32'd1, 32'(wa_q[18:1]), wd_q, 32'(PROG_CYC)};
          st = st == 9 ? 8 : 0;
        end
      endcase
    end
    wr_q = wr;
    wa_q = pins.addr;
    wd_q = pins.dq_out;
  end

  always_comb
  begin
    done_flag_n = busy == 0;
    val = st == 3 ? (pins.addr[2:1] == 2'd0 ? MFR_CODE : pins.addr[2:1] == 2'd1 ? DEV_CODE : '0)
                  : mem[pins.addr[18:1]];
    if (!pins.byte_n) val = {~last[15:8], pins.addr[0] ? val[15:8] : val[7:0]};
    // Released lines show a changing pattern so stale data never passes
    dq = (sel && acc >= ACC_CYC && rh >= RH_CYC) ? val : ~last;
  end
endmodule // flash_dev_model

//--- verif/flash_bus_mode_control_tb_top.sv
// Self-checking bench for the flash host controller against the device model
`timescale 1ns/10ps

module flash_bus_mode_control_tb_top;
  import flash_host_pkg::*;
  localparam logic [15:0] MFR = 16'h00A5; // Arbitrary identity value
  localparam logic [15:0] DEV = 16'h5A3C; // Arbitrary identity value
  typedef struct packed {
    op_t         op;
    logic [17:0] a;
    logic [15:0] d;
    logic        bm;
    logic        rd;
    logic [15:0] e;
  } row_t;
  logic        clk = 0, rst_n = 0, req_valid = 0, req_ready, rsp_valid, busy, done_flag_n;
  req_t        req = '0;
  logic [15:0] rsp_data, dev_dq, dq_in;
  pins_t       pins;
  int          err_total = 0, compares = 0, cyc = 0, hr_low = 0;
  row_t rows [25] = '{
    '{OP_READ, 18'h5, 0, 0, 1, 16'hFFFF}, '{OP_PROGRAM, 18'h5, 16'h1234, 0, 0, 0},
    '{OP_READ, 18'h5, 0, 0, 1, 16'h1234}, '{OP_READ_ID, 0, 0, 0, 0, 0},
    '{OP_READ, 18'h0, 0, 0, 1, MFR}, '{OP_READ, 18'h1, 0, 0, 1, DEV},
    '{OP_READ, 18'h1, 0, 0, 1, DEV}, '{OP_RESET_CMD, 18'h3FFFF, 0, 0, 0, 0},
    '{OP_READ, 18'h5, 0, 0, 1, 16'h1234}, '{OP_READ_ID, 0, 0, 1, 0, 0},
    '{OP_READ, 18'h0, 0, 0, 1, MFR}, '{OP_RESET_CMD, 18'h0, 0, 1, 0, 0},
    '{OP_BYPASS_ENTER, 0, 0, 0, 0, 0}, '{OP_BYPASS_PROG, 18'h6, 16'h00FF, 0, 0, 0},
    '{OP_BYPASS_PROG, 18'h7, 16'hAAAA, 0, 0, 0}, '{OP_BYPASS_EXIT, 0, 0, 0, 0, 0},
    '{OP_READ, 18'h6, 0, 0, 1, 16'h00FF}, '{OP_READ, 18'h7, 0, 0, 1, 16'hAAAA},
    '{OP_PROGRAM, 18'h20000, 16'h5555, 0, 0, 0}, '{OP_SECTOR_ERASE, 18'h5, 0, 0, 0, 0},
    '{OP_READ, 18'h5, 0, 0, 1, 16'hFFFF}, '{OP_READ, 18'h20000, 0, 0, 1, 16'h5555},
    '{OP_READ_ID, 0, 0, 0, 0, 0}, '{OP_HW_RESET, 0, 0, 0, 0, 0},
    '{OP_READ, 18'h0, 0, 0, 1, 16'hFFFF}
  };

  assign dq_in = pins.dq_oe ? pins.dq_out : dev_dq;
  always #5 clk = ~clk;

  flash_host_ctrl dut_u (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy), .pins(pins),
    .dq_in(dq_in), .done_flag_n(done_flag_n));
  flash_dev_model dev_u (.clk(clk), .pins(pins), .dq(dev_dq), .done_flag_n(done_flag_n));

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic do_req(row_t r);
    int n;
    req       = '{op: r.op, addr: r.a, data: r.d, byte_mode: r.bm};
    req_valid = 1;
    for (n = 0; n < 3000 && req_ready !== 1'b1; n++) @(posedge clk) #1;
    @(posedge clk) #1;
    req_valid = 0;
    for (n = 0; n < 3000 && (r.rd ? rsp_valid : !busy) !== 1'b1; n++) @(posedge clk) #1;
    if (n == 3000) begin
      err_total++;
      wrap_up();
    end
    if (r.rd) chk("rsp_data", r.e, rsp_data);
    @(posedge clk) #1;
    if (r.rd) chk("rsp_valid", 0, rsp_valid);
  endtask

  // Pin discipline watched on every edge out of reset
  always @(posedge clk)
  begin
    cyc++;
    if (rst_n) begin
      chk("strobes", 0, !pins.chip_select_n && !pins.output_gate_n && !pins.write_strobe_n);
      chk("dq_oe", 0, pins.dq_oe && !pins.output_gate_n);
      if (pins.hard_reset_n && hr_low > 0) chk("reset_pulse", 1, hr_low >= 50);
      hr_low = pins.hard_reset_n ? 0 : hr_low + 1;
    end
    if (cyc == 40000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    foreach (rows[i]) do_req(rows[i]);
    do_req('{OP_READ, 18'h20000, 0, 1, 1, 16'h0055});
    do_req('{OP_CHIP_ERASE, 0, 0, 0, 0, 0});
    do_req('{OP_READ, 18'h20000, 0, 0, 1, 16'hFFFF});
    rst_n = 0;
    #2 chk("reset_pins", 16'h001E, {pins.chip_select_n, pins.output_gate_n, pins.write_strobe_n,
                                   pins.hard_reset_n, pins.dq_oe});
    @(posedge clk) #1 rst_n = 1;
    @(posedge clk) #1 chk("req_ready", 1, req_ready);
    do_req('{OP_READ, 18'h6, 0, 0, 1, 16'hFFFF});
    wrap_up();
  end
endmodule // flash_bus_mode_control_tb_top
